// File: verilog/lcr_bank.sv
// Purpose: Register and fault-management logic of a laser-driver control chip
// Assumes: Byte accesses arrive from the serial front end, one per cycle, on clk
// Notes: Analog compares arrive as synchronised single-bit inputs
`timescale 1ns/10ps
`include "lcr_defs.svh"
module lcr_bank
  import lcr_pkg::*;
#(
  parameter int FAULT_RESET_CYC = 1000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire lcr_req_t req,
  input wire lcr_sense_t sense,
  input wire logic txd_pin,
  input wire logic converged,
  input wire logic [7:0] loop_bias_code,
  input wire logic [11:0] loop_mod_code,
  input wire logic loop_mod_strobe,
  output logic [7:0] rdata,
  output logic [7:0] fault_status,
  output logic [4:0] gain,
  output logic [5:0] setpoint_offset,
  output logic [7:0] n_value,
  output logic [11:0] modulation_dac_code,
  output logic [7:0] bias_dac_code,
  output logic loop_run,
  output logic excite_enable,
  output logic tx_disable,
  output logic outputs_enable,
  output logic monitor_diode_polarity,
  output logic nv_write_start,
  output logic [3:0] high_frac,
  output logic [3:0] low_frac
);
  // ----------------------------------------------------------------
  // Registers and pin sampling
  // ----------------------------------------------------------------
  logic [15:0] pwe_hi, pwe_lo, pw_hi, pw_lo, preload;
  logic [7:0] setpt, exgain, ctrl, hthr, lthr, bthr;
  logic [2:0] sd;
  logic sd_sum, alarm_b, alarm_l, alarm_h, txd_m, txd_s, txd_q;
  logic [7:0] fast_cnt, slow_cnt;
  logic [$clog2(FAULT_RESET_CYC+1)-1:0] frst_cnt;
  logic unlocked, halted, txd_int, txd_fall, fast_tick, slow_tick, bias_tick, wr_ok;

  assign unlocked = {pwe_hi, pwe_lo} == {pw_hi, pw_lo};
  assign halted = ctrl[`LCR_C_HALT];
  assign wr_ok = ce && req.wr && (unlocked || req.addr == `LCR_A_PWE_HI ||
                 req.addr == `LCR_A_PWE_HI + 8'h01 || req.addr == `LCR_A_PWE_LO ||
                 req.addr == `LCR_A_PWE_LO + 8'h01);
  assign txd_int = txd_s | ctrl[`LCR_C_SOFT_TXD];
  assign txd_fall = txd_q & ~txd_s;
  assign fast_tick = fast_cnt == 8'(`LCR_FAST_CYC - 1);
  assign slow_tick = slow_cnt == 8'(`LCR_SLOW_CYC - 1);
  assign bias_tick = converged ? slow_tick : fast_tick;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txd_m <= 1'b1;
      txd_s <= 1'b1;
      txd_q <= 1'b1;
    end else if (ce) begin
      txd_m <= txd_pin;
      txd_s <= txd_m;
      txd_q <= txd_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_cnt <= 8'h00;
      slow_cnt <= 8'h00;
    end else if (ce) begin
      fast_cnt <= fast_tick ? 8'h00 : fast_cnt + 8'h01;
      slow_cnt <= slow_tick ? 8'h00 : slow_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Register writes; byte pairs at addr and addr+1, high byte first
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwe_hi <= `LCR_RST_PWE;
      pwe_lo <= `LCR_RST_PWE;
      pw_hi <= 16'h0000;
      pw_lo <= 16'h0000;
      setpt <= 8'h00;
      exgain <= `LCR_RST_EXGAIN;
      preload <= 16'h0000;
      hthr <= 8'h00;
      lthr <= 8'h00;
      bthr <= 8'h00;
    end else if (wr_ok) begin
      unique case (req.addr)
        `LCR_A_PWE_HI: pwe_hi[15:8] <= req.wdata;
        `LCR_A_PWE_HI + 8'h01: pwe_hi[7:0] <= req.wdata;
        `LCR_A_PWE_LO: pwe_lo[15:8] <= req.wdata;
        `LCR_A_PWE_LO + 8'h01: pwe_lo[7:0] <= req.wdata;
        `LCR_A_PW_HI: pw_hi[15:8] <= req.wdata;
        `LCR_A_PW_HI + 8'h01: pw_hi[7:0] <= req.wdata;
        `LCR_A_PW_LO: pw_lo[15:8] <= req.wdata;
        `LCR_A_PW_LO + 8'h01: pw_lo[7:0] <= req.wdata;
        `LCR_A_SETPT: setpt <= req.wdata;
        `LCR_A_EXGAIN: exgain <= req.wdata;
        `LCR_A_PRELOAD: preload[15:8] <= req.wdata;
        // Low nibble stays zero: only 12 bits are held
        `LCR_A_PRELOAD + 8'h01: preload[7:4] <= req.wdata[7:4];
        `LCR_A_HTHR: hthr <= req.wdata;
        `LCR_A_LTHR: lthr <= req.wdata;
        `LCR_A_BTHR: bthr <= req.wdata;
        default: ;
      endcase
    end
  end

  // Halt is volatile and drops on supply fail even with the clock enable low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `LCR_RST_CTRL;
      nv_write_start <= 1'b0;
    end else if (sense.supply_fail) begin
      ctrl[`LCR_C_HALT] <= 1'b0;
      nv_write_start <= 1'b0;
    end else if (ce) begin
      nv_write_start <= wr_ok && req.addr == `LCR_A_CTRL;
      if (wr_ok && req.addr == `LCR_A_CTRL) begin
        ctrl <= req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarms, latched shutdowns and summary flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_b <= 1'b0;
      alarm_l <= 1'b0;
      alarm_h <= 1'b0;
    end else if (ce) begin
      if (bias_tick) begin
        alarm_b <= bthr != 8'h00 && bias_dac_code >= bthr;
      end
      if (slow_tick) begin
        alarm_l <= lthr != 8'h00 && (sense.low_transmit_power || txd_int);
        alarm_h <= hthr != 8'h00 && sense.high_transmit_power;
      end
    end
  end

  logic [2:0] alarms, enables;
  assign alarms = {alarm_h, alarm_l, alarm_b};
  assign enables = {ctrl[`LCR_C_HIGH_EN], ctrl[`LCR_C_LOW_EN], ctrl[`LCR_C_BIAS_EN]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sd
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sd[gi] <= 1'b0;
        end else if (ce) begin
          // Set wins over a clear in the same cycle
          if (alarms[gi] && enables[gi]) begin
            sd[gi] <= 1'b1;
          end else if (sense.supply_good_alarm || txd_fall) begin
            sd[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sd_sum <= 1'b0;
      frst_cnt <= '0;
    end else if (ce) begin
      if (|sd) begin
        sd_sum <= 1'b1;
        frst_cnt <= ($bits(frst_cnt))'(FAULT_RESET_CYC);
      end else if (frst_cnt != '0) begin
        frst_cnt <= frst_cnt - 1'b1;
      end else begin
        sd_sum <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_status <= 8'h00;
    end else if (ce) begin
      fault_status <= {sd_sum, sd[2], sd[1], sd[0], sense.supply_good_alarm,
                       alarm_h, alarm_l, alarm_b};
    end
  end

  // ----------------------------------------------------------------
  // Decoded settings and loop outputs
  // ----------------------------------------------------------------
  logic [7:0] setpt_eff;
  logic [7:0] n_full;
  assign setpt_eff = setpt > `LCR_SETPT_MAX ? `LCR_SETPT_MAX : setpt;
  assign n_full = {1'b0, exgain[6:0]} + 8'd32;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gain <= 5'd1;
      setpoint_offset <= 6'd32;
      n_value <= 8'd30;
      loop_run <= 1'b0;
      excite_enable <= 1'b0;
      tx_disable <= 1'b1;
      outputs_enable <= 1'b0;
      monitor_diode_polarity <= 1'b0;
      high_frac <= 4'h8;
      low_frac <= 4'h8;
    end else if (ce) begin
      unique casez (setpt_eff[7:5])
        3'b000: gain <= 5'd1;
        3'b001: gain <= 5'd2;
        3'b010: gain <= 5'd4;
        3'b011: gain <= 5'd8;
        3'b1??: gain <= 5'd16;
      endcase
      setpoint_offset <= {1'b0, setpt_eff[4:0]} + 6'd32;
      n_value <= exgain[7] ? n_full : {1'b0, n_full[7:1]};
      loop_run <= ~halted;
      excite_enable <= ~ctrl[`LCR_C_EXCITE_OFF] & ~halted;
      tx_disable <= txd_int;
      outputs_enable <= ~txd_int & ~(|sd);
      monitor_diode_polarity <= ctrl[`LCR_C_MONITOR_DIODE_POLARITY];
      high_frac <= 4'h8 + {1'b0, hthr[2:0]};
      low_frac <= 4'h8 - {1'b0, lthr[2:0]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bias_dac_code <= 8'h00;
      modulation_dac_code <= 12'h000;
    end else if (ce) begin
      // Flags clear on this same edge, so only a live fault may block the preload
      if (txd_fall && ctrl[`LCR_C_PRELOAD_EN] && !(|(alarms & enables))) begin
        modulation_dac_code <= preload[15:4];
      end else if (|sd) begin
        modulation_dac_code <= 12'h000;
      end else if (!halted && !txd_int && !ctrl[`LCR_C_EXCITE_OFF] && loop_mod_strobe) begin
        modulation_dac_code <= loop_mod_code;
      end
      if (!halted && !txd_int) begin
        bias_dac_code <= loop_bias_code;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path, registered
  // ----------------------------------------------------------------
  logic codes_ok;
  assign codes_ok = halted && unlocked;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (ce && req.rd) begin
      unique case (req.addr)
        `LCR_A_STATUS: rdata <= fault_status;
        `LCR_A_PWE_HI: rdata <= pwe_hi[15:8];
        `LCR_A_PWE_HI + 8'h01: rdata <= pwe_hi[7:0];
        `LCR_A_PWE_LO: rdata <= pwe_lo[15:8];
        `LCR_A_PWE_LO + 8'h01: rdata <= pwe_lo[7:0];
        `LCR_A_PW_HI: rdata <= unlocked ? pw_hi[15:8] : 8'h00;
        `LCR_A_PW_HI + 8'h01: rdata <= unlocked ? pw_hi[7:0] : 8'h00;
        `LCR_A_PW_LO: rdata <= unlocked ? pw_lo[15:8] : 8'h00;
        `LCR_A_PW_LO + 8'h01: rdata <= unlocked ? pw_lo[7:0] : 8'h00;
        `LCR_A_SETPT: rdata <= setpt;
        `LCR_A_EXGAIN: rdata <= exgain;
        `LCR_A_PRELOAD: rdata <= preload[15:8];
        `LCR_A_PRELOAD + 8'h01: rdata <= preload[7:0];
        `LCR_A_CTRL: rdata <= ctrl;
        `LCR_A_HTHR: rdata <= hthr;
        `LCR_A_LTHR: rdata <= lthr;
        `LCR_A_BTHR: rdata <= bthr;
        `LCR_A_BIAS: rdata <= codes_ok ? bias_dac_code : 8'h00;
        `LCR_A_MOD: rdata <= codes_ok ? modulation_dac_code[11:4] : 8'h00;
        `LCR_A_MOD + 8'h01: rdata <= codes_ok ? {modulation_dac_code[3:0], 4'h0} : 8'h00;
        default: rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  lock_write_a: assert property (@(posedge clk) disable iff (rst)
    (ce && req.wr && req.addr == `LCR_A_SETPT && !unlocked && !sense.supply_fail)
      |=> setpt == $past(setpt)) else $error("locked write changed setpoint");
  pwe_reset_a: assert property (@(posedge clk) $fell(rst) |-> {pwe_hi, pwe_lo} == 32'hFFFF_FFFF)
    else $error("entered password not all ones after reset");
  pw_hide_a: assert property (@(posedge clk) disable iff (rst)
    (ce && req.rd && req.addr == `LCR_A_PW_LO && !unlocked) |=> rdata == 8'h00)
    else $error("stored password leaked");
  summary_a: assert property (@(posedge clk) disable iff (rst)
    (ce && |sd) |=> sd_sum) else $error("summary flag not set");
  ctrl_nv_a: assert property (@(posedge clk) disable iff (rst)
    (ce && wr_ok && req.addr == `LCR_A_CTRL && !sense.supply_fail) |=> nv_write_start)
    else $error("control write did not start nv write");
  halt_fail_a: assert property (@(posedge clk) disable iff (rst)
    sense.supply_fail |=> !ctrl[`LCR_C_HALT]) else $error("halt survived supply fail");
  setpt_clamp_a: assert property (@(posedge clk) disable iff (rst)
    (ce && setpt > 8'h9F) |=> (gain == 5'd16 && setpoint_offset == 6'd63))
    else $error("setpoint not clamped");
  sd_latch_a: assert property (@(posedge clk) disable iff (rst)
    (ce && alarm_b && ctrl[`LCR_C_BIAS_EN]) |=> sd[0]) else $error("bias shutdown missing");
  txd_or_a: assert property (@(posedge clk) disable iff (rst)
    (ce && ctrl[`LCR_C_SOFT_TXD]) |=> tx_disable) else $error("soft disable ignored");
  codes_read_a: assert property (@(posedge clk) disable iff (rst)
    (ce && req.rd && req.addr == `LCR_A_BIAS && !halted) |=> rdata == 8'h00)
    else $error("bias code read while running");
endmodule

// File: verilog/lcr_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the laser control bank
// Assumes: 10 MHz block clock
// Notes: Byte addresses are the device's memory-map addresses
`ifndef LCR_DEFS_SVH
`define LCR_DEFS_SVH

`define LCR_A_STATUS 8'h78
`define LCR_A_PWE_HI 8'h7B
`define LCR_A_PWE_LO 8'h7D
`define LCR_A_SETPT 8'hB2
`define LCR_A_EXGAIN 8'hB4
`define LCR_A_PRELOAD 8'hB5
`define LCR_A_CTRL 8'hB7
`define LCR_A_HTHR 8'hB8
`define LCR_A_LTHR 8'hB9
`define LCR_A_BTHR 8'hBA
`define LCR_A_PW_HI 8'hC3
`define LCR_A_PW_LO 8'hC5
`define LCR_A_BIAS 8'hD1
`define LCR_A_MOD 8'hD6

`define LCR_RST_PWE 16'hFFFF
`define LCR_RST_EXGAIN 8'h1C
`define LCR_RST_CTRL 8'h70
`define LCR_SETPT_MAX 8'h9F

`define LCR_C_HALT 0
`define LCR_C_EXCITE_OFF 1
`define LCR_C_SOFT_TXD 2
`define LCR_C_MONITOR_DIODE_POLARITY 3
`define LCR_C_BIAS_EN 4
`define LCR_C_LOW_EN 5
`define LCR_C_HIGH_EN 6
`define LCR_C_PRELOAD_EN 7

`define LCR_CLK_MHZ 10
`define LCR_FAST_US 4
`define LCR_SLOW_US 16
`define LCR_FAST_CYC (`LCR_FAST_US * `LCR_CLK_MHZ)
`define LCR_SLOW_CYC (`LCR_SLOW_US * `LCR_CLK_MHZ)
`endif

// File: verilog/lcr_pkg.sv
// Purpose: Types of the laser control bank
// Assumes: Nothing
// Notes: Register access travels as one packed struct
package lcr_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lcr_req_t;

  typedef struct packed {
    logic high_bias_current;
    logic low_transmit_power;
    logic high_transmit_power;
    logic supply_good_alarm;
    logic supply_fail;
  } lcr_sense_t;
endpackage

// File: testbench/lcr_host.sv
// Purpose: Behavioural serial host that issues byte accesses to the bank
// Assumes: Requests launched and dropped at falling edges of clk
// Notes: One idle cycle separates accesses, so no signal is driven twice in a step
`timescale 1ns/10ps
`include "lcr_defs.svh"
module lcr_host
  import lcr_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output lcr_req_t req
);
  initial req = '0;

  // Read data is taken at the falling edge after the capturing rising edge
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge clk) req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk) req <= '0;
    q = rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(1'b1, a, d, q);
  endtask

  // High byte first at the lower address
  task automatic wr32(input logic [7:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      wr(a + 8'(i), v[31 - 8 * i -: 8]);
    end
  endtask

  // Leave a non-matching key so it cannot be read back
  task automatic scrub();
    wr32(`LCR_A_PWE_HI, 32'hFFFF_FFFF);
  endtask
endmodule

// File: testbench/tb_lcr_bank.sv
// Purpose: Self-checking bench of the laser control bank
// Assumes: Inputs change at falling edges; fault reset shortened to 5 cycles
// Notes: Expectations computed here from integers, never from the design
`timescale 1ns/10ps
`include "lcr_defs.svh"
module tb_lcr_bank
  import lcr_pkg::*;
;
  logic clk, rst, ce, txd_pin, converged, loop_mod_strobe;
  lcr_req_t req;
  lcr_sense_t sense;
  logic [7:0] loop_bias_code, rdata, fault_status, n_value, bias_dac_code, q;
  logic [11:0] loop_mod_code, modulation_dac_code;
  logic [4:0] gain;
  logic [5:0] setpoint_offset;
  logic [3:0] high_frac, low_frac;
  logic loop_run, excite_enable, tx_disable, outputs_enable;
  logic monitor_diode_polarity, nv_write_start;
  logic [31:0] seed = 50;
  logic [31:0] pw;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int v;

  lcr_bank #(.FAULT_RESET_CYC(5)) lcr_bank_inst (.clk, .rst, .ce, .req, .sense, .txd_pin,
    .converged, .loop_bias_code, .loop_mod_code, .loop_mod_strobe, .rdata, .fault_status,
    .gain, .setpoint_offset, .n_value, .modulation_dac_code, .bias_dac_code, .loop_run,
    .excite_enable, .tx_disable, .outputs_enable, .monitor_diode_polarity,
    .nv_write_start, .high_frac, .low_frac);
  lcr_host lcr_host_inst (.clk(clk), .rdata(rdata), .req(req));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    lcr_host_inst.access(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic final_report();
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs about 700 cycles; a hang is cut well after that
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    txd_pin = 1'b0;
    converged = 1'b0;
    loop_mod_strobe = 1'b0;
    sense = '0;
    loop_bias_code = 8'h3F;
    loop_mod_code = 12'h000;
    cyc(20);
    rst = 1'b0;
    // ----------------------------------------
    // Reset values and locked writes
    // ----------------------------------------
    rdc("exgain", `LCR_A_EXGAIN, 8'h1C);
    rdc("control", `LCR_A_CTRL, 8'h70);
    rdc("pwe", `LCR_A_PWE_LO, 8'hFF);
    rdc("pw", `LCR_A_PW_HI, 8'h00);
    chk("n", 16'd30, n_value);
    lcr_host_inst.wr(`LCR_A_SETPT, 8'h85);
    rdc("setpt", `LCR_A_SETPT, 8'h00);
    lcr_host_inst.wr32(`LCR_A_PWE_HI, 32'h0000_0000);
    // ----------------------------------------
    // Decoded setpoint and extinction gain
    // ----------------------------------------
    for (int i = 0; i < 8; i++) begin
      q = (i == 0) ? 8'hA0 : rnd();
      lcr_host_inst.wr(`LCR_A_SETPT, q);
      cyc(1);
      v = (q > 8'h9F) ? 8'h9F : q;
      chk("gain", 16'(1 << ((v >> 5) > 4 ? 4 : v >> 5)), gain);
      chk("offset", 16'(v % 32 + 32), setpoint_offset);
      q = (i == 0) ? 8'hE8 : rnd();
      lcr_host_inst.wr(`LCR_A_EXGAIN, q);
      cyc(1);
      v = q % 128 + 32;
      chk("n", 16'(q[7] ? v : v / 2), n_value);
    end
    // ----------------------------------------
    // Stored key and preload
    // ----------------------------------------
    pw = {rnd(), rnd(), rnd(), rnd()};
    // Each stored byte locks the bank until the entered copy catches up
    for (int i = 0; i < 4; i++) begin
      lcr_host_inst.wr(`LCR_A_PW_HI + 8'(i), pw[31 - 8 * i -: 8]);
      lcr_host_inst.wr(`LCR_A_PWE_HI + 8'(i), pw[31 - 8 * i -: 8]);
    end
    lcr_host_inst.wr(`LCR_A_PWE_HI, ~pw[31:24]);
    rdc("pw", `LCR_A_PW_HI, 8'h00);
    lcr_host_inst.wr(`LCR_A_PWE_HI, pw[31:24]);
    rdc("pw", `LCR_A_PW_LO, pw[15:8]);
    lcr_host_inst.wr(`LCR_A_PRELOAD, 8'hAB);
    lcr_host_inst.wr(`LCR_A_PRELOAD + 8'h01, 8'hCF);
    rdc("preload", `LCR_A_PRELOAD + 8'h01, 8'hC0);
    // ----------------------------------------
    // Control byte
    // ----------------------------------------
    lcr_host_inst.wr(`LCR_A_CTRL, 8'h7E);
    chk("nvstart", 16'd1, nv_write_start);
    cyc(4);
    chk("txd", 16'd1, tx_disable);
    chk("outen", 16'd0, outputs_enable);
    chk("excite", 16'd0, excite_enable);
    chk("monitor_diode_polarity", 16'd1, monitor_diode_polarity);
    lcr_host_inst.wr(`LCR_A_CTRL, 8'hF0);
    txd_pin = 1'b1;
    cyc(4);
    chk("txd", 16'd1, tx_disable);
    txd_pin = 1'b0;
    // ----------------------------------------
    // Bias alarm, latched shutdown, preload on release
    // ----------------------------------------
    lcr_host_inst.wr(`LCR_A_BTHR, 8'h40);
    cyc(50);
    chk("status", 16'h00, fault_status);
    loop_bias_code = 8'h40;
    cyc(50);
    chk("status", 16'h91, fault_status);
    chk("mod", 16'h000, modulation_dac_code);
    loop_bias_code = 8'h10;
    cyc(50);
    chk("status", 16'h90, fault_status);
    txd_pin = 1'b1;
    cyc(4);
    txd_pin = 1'b0;
    for (v = 0; v < 20 && fault_status[4] !== 1'b0; v++) cyc(1);
    chk("summary", 16'd1, fault_status[7]);
    cyc(10);
    chk("status", 16'h00, fault_status);
    chk("mod", 16'hABC, modulation_dac_code);
    // ----------------------------------------
    // Transmit power alarms at the slow refresh
    // ----------------------------------------
    converged = 1'b1;
    lcr_host_inst.wr(`LCR_A_LTHR, 8'h03);
    lcr_host_inst.wr(`LCR_A_HTHR, 8'h02);
    lcr_host_inst.wr(`LCR_A_CTRL, 8'h04);
    sense.high_transmit_power = 1'b1;
    cyc(170);
    chk("status", 16'h06, fault_status);
    chk("lowfrac", 16'd5, low_frac);
    chk("highfrac", 16'd10, high_frac);
    sense.high_transmit_power = 1'b0;
    lcr_host_inst.wr(`LCR_A_CTRL, 8'h00);
    cyc(170);
    chk("status", 16'h00, fault_status);
    // ----------------------------------------
    // Halt, code readback, supply events
    // ----------------------------------------
    loop_mod_code = 12'h123;
    loop_mod_strobe = 1'b1;
    cyc(2);
    chk("mod", 16'h123, modulation_dac_code);
    lcr_host_inst.wr(`LCR_A_CTRL, 8'h02);
    loop_mod_code = 12'h456;
    cyc(2);
    chk("mod", 16'h123, modulation_dac_code);
    loop_mod_strobe = 1'b0;
    loop_bias_code = 8'h35;
    cyc(4);
    rdc("bias", `LCR_A_BIAS, 8'h00);
    lcr_host_inst.wr(`LCR_A_CTRL, 8'h01);
    loop_bias_code = 8'h33;
    cyc(4);
    chk("run", 16'd0, loop_run);
    chk("bias", 16'h35, bias_dac_code);
    rdc("bias", `LCR_A_BIAS, 8'h35);
    rdc("mod", `LCR_A_MOD, 8'h12);
    lcr_host_inst.access(1'b0, `LCR_A_MOD + 8'h01, 8'h00, q);
    chk("modlow", 16'h30, q);
    lcr_host_inst.scrub();
    rdc("pw", `LCR_A_PW_HI, 8'h00);
    rdc("pw", `LCR_A_PW_LO, 8'h00);
    sense.supply_fail = 1'b1;
    cyc(4);
    chk("run", 16'd1, loop_run);
    sense.supply_good_alarm = 1'b1;
    cyc(4);
    chk("poa", 16'd1, fault_status[3]);
    final_report();
  end
endmodule
